// *** bench/aecr_props.sv ***
// Checker on the serial link between host and device.
// Assumes clk_sys samples every link signal and rst is async, active high.
`timescale 1ns/1ps
module aecr_props (
	// System
	input wire logic clk_sys,
	input wire logic rst,
	// Link
	input wire logic sclk,
	input wire logic sdata,
	input wire logic sel_n
);
	logic sclk_reg;
	logic [5:0] cnt_reg;
	logic [31:0] sh_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////
	// Frame capture
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_reg <= 1'b0;
			cnt_reg <= 6'h00;
			sh_reg <= 32'h0;
		end else begin
			sclk_reg <= sclk;
			if (sel_n) begin
				cnt_reg <= 6'h00;
			end else if (sclk && !sclk_reg) begin
				cnt_reg <= cnt_reg + 6'h01;
				sh_reg <= {sh_reg[30:0], sdata};
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Wire rules
	a_idle_clock_low: assert property (sel_n |-> !sclk) else $error("sclk high while idle");
	a_clock_high_time: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("sclk high phase wrong");
	a_data_hold: assert property (sclk && $past(sclk) |-> $stable(sdata))
		else $error("sdata moved while sclk high");
	a_select_lead: assert property ($fell(sel_n) |-> !sclk ##[1:8] sclk)
		else $error("no sclk after select");
	a_frame_length: assert property ($rose(sel_n) |-> cnt_reg == 6'h20)
		else $error("frame not 32 bits");
	a_frame_header: assert property ($rose(sel_n) |-> sh_reg[31:20] == aecr_pkg::HEADER)
		else $error("bad frame header");
	a_setup_bits: assert property ($rose(sel_n) && sh_reg[19:16] == 4'h9
		|-> !sh_reg[11] && &sh_reg[9:0]) else $error("setup fixed bits wrong");
	a_fine_ones: assert property ($rose(sel_n) && sh_reg[19:16] == 4'hE |-> &sh_reg[7:0])
		else $error("fine low bits not ones");
	a_low_ones: assert property ($rose(sel_n) && sh_reg[19:16] inside {4'h2, 4'h3, 4'hA,
		4'hB, 4'hF} |-> &sh_reg[6:0]) else $error("low bits not ones");
	a_gain_range: assert property ($rose(sel_n) && sh_reg[18:16] == 3'h3
		|-> sh_reg[15:7] inside {[9'h040:9'h1C0]}) else $error("gain out of range");
	c_frame: cover property ($rose(sel_n));
	c_setup: cover property ($rose(sel_n) && sh_reg[19:16] == 4'h9);
	c_gain: cover property ($rose(sel_n) && sh_reg[18:16] == 3'h3);
endmodule

// *** bench/tb_top.sv ***
// Bench joining host and device over the link, driven over Avalon-MM.
// Assumes one frame per accepted command write.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 0;
	logic rst = 1;
	logic [3:0] avs_address = 0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, pattern_active;
	logic cal_running = 0;
	logic output_clock_sync_reset = 0;
	logic [7:0] ofs_a_mag, ofs_b_mag, fine_delay;
	logic ofs_a_neg, ofs_b_neg, pattern_output_enable, termination_trim_skip;
	logic output_data_clock_keep, interleave_enable_field, input_source_choice;
	logic low_rate_interleave_tune, sample_clock_invert;
	logic [8:0] gain_a_code, gain_b_code;
	logic [4:0] coarse_delay;
	logic [2:0] mid_delay;
	logic [15:0] er [16];
	logic [3:0] at [8] = '{4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF, 4'h4};
	int error_cnt = 0, n_checks = 0, cyc = 0, seed = 32'h86C45F0D;
	wire [58:0] dv = {ofs_a_mag, ofs_a_neg, ofs_b_mag, ofs_b_neg, gain_a_code, gain_b_code,
		pattern_output_enable, termination_trim_skip, output_data_clock_keep,
		interleave_enable_field, input_source_choice, low_rate_interleave_tune, fine_delay,
		sample_clock_invert, coarse_delay, mid_delay};
	aecr_link_if link ();
	aecr_host u_aecr_host (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .cal_running, .link(link.host));
	aecr_device u_aecr_device (.clk_sys, .rst, .link(link.device), .output_clock_sync_reset,
		.ofs_a_mag, .ofs_a_neg, .ofs_b_mag, .ofs_b_neg, .gain_a_code, .gain_b_code,
		.pattern_output_enable, .pattern_active, .termination_trim_skip,
		.output_data_clock_keep, .interleave_enable_field, .input_source_choice,
		.low_rate_interleave_tune, .fine_delay, .sample_clock_invert, .coarse_delay, .mid_delay);
	aecr_props u_aecr_props (.clk_sys, .rst, .sclk(link.sclk), .sdata(link.sdata),
		.sel_n(link.sel_n));
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		@(posedge clk_sys);
	endtask
	function automatic logic [15:0] fix(input logic [3:0] a, input logic [15:0] d);
		logic [8:0] g;
		g = d[15:7];
		case (a)
			4'h9: fix = (d & 16'hF400) | 16'h03FF;
			4'hE: fix = d | 16'h00FF;
			4'h3, 4'hB: fix = {g < 9'h040 ? 9'h040 : g > 9'h1C0 ? 9'h1C0 : g, 7'h7F};
			default: fix = d | 16'h007F;
		endcase
	endfunction
	function automatic logic [58:0] expv();
		logic [15:0] s;
		s = er[9];
		return {er[2][15:7], er[10][15:7], er[3][15:7], er[11][15:7], s[15], s[14], s[14],
			s[13], s[12], s[10] & s[13], er[14][15:8], er[15][15:7]};
	endfunction
	task automatic send(input logic [3:0] a, input logic [15:0] d);
		int z;
		z = 0;
		bus(1, 0, {12'h0, a, d});
		repeat (100) @(posedge clk_sys);
		check(dv, expv());
		er[a] = fix(a, d);
		while (z < 3) begin
			bus(0, 1, 0);
			z = rd[0] ? 0 : z + 1;
		end
		repeat (5) @(posedge clk_sys);
		check(dv, expv());
	endtask
	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		er[2] = 16'h007F;
		er[10] = 16'h007F;
		er[3] = 16'h807F;
		er[11] = 16'h807F;
		er[9] = 16'h03FF;
		er[14] = 16'h00FF;
		er[15] = 16'h007F;
		repeat (8) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		check(dv, expv());
		cal_running <= 1;
		bus(0, 5, 0);
		bus(0, 5, 0);
		check(rd, 0);
		bus(0, 1, 0);
		bus(0, 1, 0);
		check(rd[1:0], 2'b10);
		fork
			send(4'h3, 16'h0000);
			begin
				repeat (20) begin
					@(negedge clk_sys);
					check(avs_waitrequest, 1);
				end
				@(posedge clk_sys);
				cal_running <= 0;
			end
		join
		send(4'hB, 16'hFFFF);
		send(4'h2, 16'h0000);
		send(4'h2, 16'h0080);
		send(4'h4, 16'h1234);
		output_clock_sync_reset <= 1;
		send(4'h9, 16'h8000);
		check(pattern_active, 0);
		output_clock_sync_reset <= 0;
		repeat (6) @(posedge clk_sys);
		check(pattern_active, 1);
		send(4'h9, 16'h0400);
		send(4'h9, 16'h2400);
		check(pattern_active, 0);
		send(4'h9, 16'h5000);
		send(4'hE, 16'h0100);
		send(4'hF, 16'h8480);
		repeat (24) send(at[3'($random(seed))], 16'($random(seed)));
		results();
	end
endmodule

// *** core/aecr_device.sv ***
// Device end: serial receiver and extended control register bank.
// Assumes the host shifts data on the falling serial edge, MSB first.
//
// Implementation choice: the Avalon-MM slave port sits in aecr_host, not here.
`timescale 1ns/1ps
module aecr_device (
	// System
	input wire logic clk_sys,
	input wire logic rst,
	// Link
	aecr_link_if.device link,
	// Output clock sync reset
	input wire logic output_clock_sync_reset,
	// Offset trims
	output logic [7:0] ofs_a_mag,
	output logic ofs_a_neg,
	output logic [7:0] ofs_b_mag,
	output logic ofs_b_neg,
	// Gain trims
	output logic [8:0] gain_a_code,
	output logic [8:0] gain_b_code,
	// Setup word
	output logic pattern_output_enable,
	output logic pattern_active,
	output logic termination_trim_skip,
	output logic output_data_clock_keep,
	output logic interleave_enable_field,
	output logic input_source_choice,
	output logic low_rate_interleave_tune,
	// Sample clock phase
	output logic [7:0] fine_delay,
	output logic sample_clock_invert,
	output logic [4:0] coarse_delay,
	output logic [2:0] mid_delay
);
	////////////////////////////////////////////////////////////////
	// Synchronisers
	logic [2:0] sclk_s;
	logic [1:0] sdat_s;
	logic [1:0] sel_s;
	logic [1:0] syr_s;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_s <= 3'h0;
			sdat_s <= 2'h0;
			sel_s <= 2'h3;
			syr_s <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], link.sclk};
			sdat_s <= {sdat_s[0], link.sdata};
			sel_s <= {sel_s[0], link.sel_n};
			syr_s <= {syr_s[0], output_clock_sync_reset};
		end
	end
	wire rise = sclk_s[1] & ~sclk_s[2];
	////////////////////////////////////////////////////////////////
	// Frame shifter
	logic [31:0] shift_reg;
	logic [5:0] count_reg;
	logic done_reg;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_reg <= 32'h0;
			count_reg <= 6'h0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (sel_s[1]) begin
				count_reg <= 6'h0;
			end else if (rise) begin
				shift_reg <= {shift_reg[30:0], sdat_s[1]};
				if (count_reg == 6'(aecr_pkg::FRAME_BITS - 1)) begin
					count_reg <= 6'h0;
					done_reg <= 1'b1;
				end else begin
					count_reg <= count_reg + 6'h1;
				end
			end
		end
	end
	wire frame_ok = done_reg && shift_reg[31:20] == aecr_pkg::HEADER;
	wire [3:0] f_addr = shift_reg[19:16];
	wire [15:0] f_data = shift_reg[15:0];
	////////////////////////////////////////////////////////////////
	// Register bank, write only
	logic [15:0] ofs_a_reg;
	logic [15:0] ofs_b_reg;
	logic [15:0] gain_a_reg;
	logic [15:0] gain_b_reg;
	logic [15:0] setup_reg;
	logic [15:0] fine_reg;
	logic [15:0] coarse_reg;

	// Write strobe for one address
	function automatic logic wr_hit(input logic ok, input logic [3:0] fa, input logic [3:0] a);
		return ok && (fa == a);
	endfunction

	// Channel A offset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ofs_a_reg <= aecr_pkg::RST_OFS;
		end else if (wr_hit(frame_ok, f_addr, aecr_pkg::ADDR_OFS_A)) begin
			ofs_a_reg <= f_data;
		end
	end

	// Channel B offset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ofs_b_reg <= aecr_pkg::RST_OFS;
		end else if (wr_hit(frame_ok, f_addr, aecr_pkg::ADDR_OFS_B)) begin
			ofs_b_reg <= f_data;
		end
	end

	// Channel A gain, live without recalibration
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			gain_a_reg <= aecr_pkg::RST_GAIN;
		end else if (wr_hit(frame_ok, f_addr, aecr_pkg::ADDR_GAIN_A)) begin
			gain_a_reg <= f_data;
		end
	end

	// Channel B gain, live without recalibration
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			gain_b_reg <= aecr_pkg::RST_GAIN;
		end else if (wr_hit(frame_ok, f_addr, aecr_pkg::ADDR_GAIN_B)) begin
			gain_b_reg <= f_data;
		end
	end

	// Setup word
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			setup_reg <= aecr_pkg::RST_SETUP;
		end else if (wr_hit(frame_ok, f_addr, aecr_pkg::ADDR_SETUP)) begin
			setup_reg <= f_data;
		end
	end

	// Fine phase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fine_reg <= aecr_pkg::RST_FINE;
		end else if (wr_hit(frame_ok, f_addr, aecr_pkg::ADDR_FINE)) begin
			fine_reg <= f_data;
		end
	end

	// Coarse phase and polarity
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			coarse_reg <= aecr_pkg::RST_COARSE;
		end else if (wr_hit(frame_ok, f_addr, aecr_pkg::ADDR_COARSE)) begin
			coarse_reg <= f_data;
		end
	end

	////////////////////////////////////////////////////////////////
	// Field decoding shared by both channels
	function automatic logic [7:0] ofs_mag(input logic [15:0] r);
		return r[aecr_pkg::MAG_MSB:aecr_pkg::MAG_LSB];
	endfunction
	function automatic logic ofs_neg(input logic [15:0] r);
		return r[aecr_pkg::BIT_SIGN];
	endfunction
	function automatic logic [8:0] gain_code(input logic [15:0] r);
		return r[aecr_pkg::GAIN_MSB:aecr_pkg::GAIN_LSB];
	endfunction

	////////////////////////////////////////////////////////////////
	// Pattern gating by sync reset
	// Held off while sync reset is high so all ports start together
	logic pat_reg;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pat_reg <= 1'b0;
		end else if (!setup_reg[aecr_pkg::BIT_PATTERN]) begin
			pat_reg <= 1'b0;
		end else if (!syr_s[1]) begin
			pat_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Field outputs
	always_comb begin
		ofs_a_mag = ofs_mag(ofs_a_reg);
		ofs_a_neg = ofs_neg(ofs_a_reg);
		ofs_b_mag = ofs_mag(ofs_b_reg);
		ofs_b_neg = ofs_neg(ofs_b_reg);
		gain_a_code = gain_code(gain_a_reg);
		gain_b_code = gain_code(gain_b_reg);
		pattern_output_enable = setup_reg[aecr_pkg::BIT_PATTERN];
		pattern_active = pat_reg;
		termination_trim_skip = setup_reg[aecr_pkg::BIT_TRIM_SKIP];
		output_data_clock_keep = setup_reg[aecr_pkg::BIT_TRIM_SKIP];
		interleave_enable_field = setup_reg[aecr_pkg::BIT_INTERLEAVE];
		input_source_choice = setup_reg[aecr_pkg::BIT_SOURCE];
		// Low rate tuning only matters while interleaved
		low_rate_interleave_tune = setup_reg[aecr_pkg::BIT_LOW_RATE]
			& setup_reg[aecr_pkg::BIT_INTERLEAVE];
		fine_delay = fine_reg[aecr_pkg::FINE_MSB:aecr_pkg::FINE_LSB];
		sample_clock_invert = coarse_reg[aecr_pkg::BIT_INVERT];
		coarse_delay = coarse_reg[aecr_pkg::COARSE_MSB:aecr_pkg::COARSE_LSB];
		mid_delay = coarse_reg[aecr_pkg::MID_MSB:aecr_pkg::MID_LSB];
	end
endmodule

// *** core/aecr_host.sv ***
// Host end: Avalon-MM command registers and serial frame sender.
// Holds command writes with waitrequest while the converter calibrates.
`timescale 1ns/1ps
module aecr_host (
	// System
	input wire logic clk_sys,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Calibration state
	input wire logic cal_running,
	// Link
	aecr_link_if.host link
);
	////////////////////////////////////////////////////////////////
	// Frame fill: forced bits and clamps
	function automatic logic [15:0] fill(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] r;
		r = d;
		case (a)
			aecr_pkg::ADDR_SETUP: r = (d & aecr_pkg::SETUP_MASK) | aecr_pkg::SETUP_FORCE;
			aecr_pkg::ADDR_FINE: r = d | aecr_pkg::LOW8_ONES;
			aecr_pkg::ADDR_GAIN_A, aecr_pkg::ADDR_GAIN_B: begin
				r = d | aecr_pkg::LOW7_ONES;
				if (d[15:7] < aecr_pkg::GAIN_MIN) r[15:7] = aecr_pkg::GAIN_MIN;
				if (d[15:7] > aecr_pkg::GAIN_MAX) r[15:7] = aecr_pkg::GAIN_MAX;
			end
			default: r = d | aecr_pkg::LOW7_ONES;
		endcase
		return r;
	endfunction
	////////////////////////////////////////////////////////////////
	// Sender state
	typedef enum logic [1:0] {ST_IDLE, ST_SEND} aecr_st_e;
	aecr_st_e st_reg;
	logic [31:0] sh_reg;
	logic [5:0] bit_reg;
	logic [2:0] div_reg;
	logic sclk_reg, sel_n_reg;
	logic [1:0] cal_s;
	logic rvalid_reg;
	// Calibration flag comes from outside: two flip-flops first
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cal_s <= 2'h0;
		end else begin
			cal_s <= {cal_s[0], cal_running};
		end
	end
	wire cal_busy = cal_s[1];
	wire cmd_hit = avs_write && avs_address == aecr_pkg::AVS_CMD[5:2];
	wire stat_hit = avs_address == aecr_pkg::AVS_STATUS[5:2];
	wire accept = cmd_hit && st_reg == ST_IDLE && !cal_busy;
	// Reads wait one cycle so registered data stands when waitrequest drops
	assign avs_waitrequest = (cmd_hit && !accept) || (avs_read && !rvalid_reg);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
			rvalid_reg <= 1'b0;
		end else if (avs_read && !rvalid_reg) begin
			avs_readdata <= stat_hit ? {30'h0, cal_busy, st_reg == ST_SEND} : 32'h0;
			rvalid_reg <= 1'b1;
		end else begin
			rvalid_reg <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= ST_IDLE;
			sh_reg <= 32'h0;
			bit_reg <= 6'h0;
			div_reg <= 3'h0;
			sclk_reg <= 1'b0;
			sel_n_reg <= 1'b1;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					sclk_reg <= 1'b0;
					sel_n_reg <= 1'b1;
					if (accept) begin
						sh_reg <= {aecr_pkg::HEADER, avs_writedata[19:16],
							fill(avs_writedata[19:16], avs_writedata[15:0])};
						bit_reg <= 6'h0;
						div_reg <= 3'h0;
						sel_n_reg <= 1'b0;
						st_reg <= ST_SEND;
					end
				end
				ST_SEND: begin
					div_reg <= div_reg + 3'h1;
					if (div_reg == 3'(aecr_pkg::LINK_DIV / 2 - 1)) begin
						sclk_reg <= 1'b1;
					end else if (div_reg == 3'(aecr_pkg::LINK_DIV - 1)) begin
						sclk_reg <= 1'b0;
						sh_reg <= {sh_reg[30:0], 1'b0};
						if (bit_reg == 6'(aecr_pkg::FRAME_BITS - 1)) begin
							st_reg <= ST_IDLE;
							sel_n_reg <= 1'b1;
						end else begin
							bit_reg <= bit_reg + 6'h1;
						end
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end
	assign link.sclk = sclk_reg;
	assign link.sdata = sh_reg[31];
	assign link.sel_n = sel_n_reg;
endmodule

// *** core/aecr_link_if.sv ***
// Three-wire serial link between host and device.
// Assumes both ends sit on the same system clock; the serial clock is sampled.
`timescale 1ns/1ps
interface aecr_link_if;
	logic sclk;
	logic sdata;
	logic sel_n;
	modport host (output sclk, output sdata, output sel_n);
	modport device (input sclk, input sdata, input sel_n);
endinterface

// *** core/aecr_pkg.sv ***
// Constants shared by both ends of the extended control register link.
// Assumes a 100 MHz system clock on both ends and a serial clock made by the host.
package aecr_pkg;
	localparam int FRAME_BITS = 32;
	localparam logic [11:0] HEADER = 12'h001;
	localparam logic [3:0] ADDR_OFS_A = 4'h2;
	localparam logic [3:0] ADDR_GAIN_A = 4'h3;
	localparam logic [3:0] ADDR_SETUP = 4'h9;
	localparam logic [3:0] ADDR_OFS_B = 4'hA;
	localparam logic [3:0] ADDR_GAIN_B = 4'hB;
	localparam logic [3:0] ADDR_FINE = 4'hE;
	localparam logic [3:0] ADDR_COARSE = 4'hF;
	localparam logic [15:0] RST_OFS = 16'h007F;
	localparam logic [15:0] RST_GAIN = 16'h807F;
	localparam logic [15:0] RST_SETUP = 16'h03FF;
	localparam logic [15:0] RST_FINE = 16'h00FF;
	localparam logic [15:0] RST_COARSE = 16'h007F;
	localparam logic [15:0] SETUP_MASK = 16'hF400;
	localparam logic [15:0] SETUP_FORCE = 16'h03FF;
	localparam logic [15:0] LOW7_ONES = 16'h007F;
	localparam logic [15:0] LOW8_ONES = 16'h00FF;
	localparam int BIT_PATTERN = 15;
	localparam int BIT_TRIM_SKIP = 14;
	localparam int BIT_INTERLEAVE = 13;
	localparam int BIT_SOURCE = 12;
	localparam int BIT_LOW_RATE = 10;
	localparam int BIT_SIGN = 7;
	localparam int BIT_INVERT = 15;
	localparam int MAG_MSB = 15;
	localparam int MAG_LSB = 8;
	localparam int GAIN_MSB = 15;
	localparam int GAIN_LSB = 7;
	localparam int FINE_MSB = 15;
	localparam int FINE_LSB = 8;
	localparam int COARSE_MSB = 14;
	localparam int COARSE_LSB = 10;
	localparam int MID_MSB = 9;
	localparam int MID_LSB = 7;
	localparam logic [8:0] GAIN_MIN = 9'h040;
	localparam logic [8:0] GAIN_MAX = 9'h1C0;
	localparam logic [4:0] COARSE_LIMIT = 5'h1F;
	localparam int LINK_DIV = 8;
	localparam logic [31:0] AVS_CMD = 32'h0;
	localparam logic [31:0] AVS_STATUS = 32'h4;
endpackage
